// [lcd_core_map.svh]
// Register offsets, field positions, reset values and timing of the LCD control core
`ifndef LCD_CORE_MAP_SVH
`define LCD_CORE_MAP_SVH
`define LCD_OFS_INSTR    8'h00
`define LCD_OFS_DATA     8'h04
`define LCD_OFS_MODE     8'h08
`define LCD_STAT_BUSY    7
`define LCD_CLK_NS       8
`define LCD_T_POWER_NS   10000000
`define LCD_T_HOLD_NS    1200000
`define LCD_T_CLEAR_NS   2890000
`define LCD_T_SHORT_NS   223000
`define LCD_T_READ_NS    312000
`define LCD_SPACE        8'h20
`define LCD_DD_LAST      7'h0B
`define LCD_CG_BASE      7'h40
`define LCD_CG_LAST      7'h5F
`define LCD_MK_BASE      7'h60
`define LCD_MK_LAST      7'h64
`define LCD_ICON_ROW     5'h10
`define LCD_LAST_SHIFT   8'h1D
`define LCD_LATCH_SLOT   8'h1E
`define LCD_ROW_CYC      64
`define LCD_BLINK_FRAMES 32
`endif

// [lcd_core_pkg.sv]
// Types shared by the LCD control core
package lcd_core_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_PIN} ctl_state_t;
endpackage : lcd_core_pkg

// [lcd_ctl_core.sv]
// LCD control core: APB instruction/data port, memories, busy timing and display scan
// Operation
// - Up to 24 icons, lit by a 1 in data bits 0..4 of icon memory.
// - Icon state changes only by icon memory writes or display on/off.
// - Icon bit to screen position mapping ignores display shift.
// - Icon memory at 60h..64h, bit 4 first, bits 7..5 and 64h bit 0 unused.
// - Icons for characters 1-6 and 7-12 drive their fixed segment lists.
// - Icon memory is never cleared by power-on or pin reset.
// - Display refresh reads run independently of host accesses.
// - 17 commons, 30 segments; only the selected common is active.
// - Thirty bits shift serially, latched to segments after all thirty.
// - Cursor and blink sit at the address counter's character position.
// - Cursor and blink still show when the counter holds a glyph address.
// - Power-up runs initialisation and stays busy for 10 ms.
// - Reset pin low longer than 1.2 ms starts a reset sequence.
// - After the reset pin rises, busy 10 ms and refuse instructions.
// - Instructions and data held in separate holding registers.
// - Code 01h clears display, address counter to 0, busy 2.89 ms.
// - Code 02h/03h homes address counter and shift, busy 223 us.
// - Code 04h..07h sets direction and shift-on-write, busy 223 us.
// - Clear fills text memory with 20h and forces increment.
// - Status read returns busy flag and address counter.
// - Code 08h..0Fh sets display, cursor, blink; display gates icons.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "lcd_core_map.svh"

module lcd_ctl_core #(
  parameter int unsigned POWER_CYC    = (`LCD_T_POWER_NS + `LCD_CLK_NS - 1) / `LCD_CLK_NS,
  parameter int unsigned HOLD_CYC     = (`LCD_T_HOLD_NS + `LCD_CLK_NS - 1) / `LCD_CLK_NS,
  parameter int unsigned CLEAR_CYC    = (`LCD_T_CLEAR_NS + `LCD_CLK_NS - 1) / `LCD_CLK_NS,
  parameter int unsigned SHORT_CYC    = (`LCD_T_SHORT_NS + `LCD_CLK_NS - 1) / `LCD_CLK_NS,
  parameter int unsigned READ_CYC     = (`LCD_T_READ_NS + `LCD_CLK_NS - 1) / `LCD_CLK_NS,
  parameter int unsigned ROW_CYC      = `LCD_ROW_CYC,
  parameter int unsigned BLINK_FRAMES = `LCD_BLINK_FRAMES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RESET_PIN_N,
  output logic      [16:0] COM,
  output logic      [29:0] SEG
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and state

  logic [7:0]  display_text_memory [12];
  logic [4:0]  glyph_memory        [32];
  logic [4:0]  icon_memory         [5];
  logic [6:0]  address_counter;
  logic        inc_dir, shift_en, disp_on, cur_on, blk_on;
  logic [3:0]  shift_off, chr, txt, cursor_pos;
  lcd_core_pkg::ctl_state_t state;
  logic [23:0] busy_cnt, low_cnt;
  logic [7:0]  instruction_holding_reg, data_holding_reg;
  logic        ir_go, dr_go, busy_indicator;
  logic        pin_meta, pin_s2, pin_s3, pin_level, pin_hit;
  logic        setup_ph, access_ph, wr_instr, wr_data, rd_data, addr_ok;
  logic [4:0]  row, seg_j, glyph;
  logic [7:0]  bcnt, frame_cnt, code;
  logic [29:0] shreg;
  logic        blink_phase, px;
  logic [2:0]  col;

  // Segment index (0-based) of icons 1..24; first twelve over characters 1-6
  localparam logic [4:0] ICON_SEG [24] = '{5'h01, 5'h03, 5'h06, 5'h08, 5'h0B, 5'h0D, 5'h10, 5'h12,
                                           5'h15, 5'h17, 5'h1A, 5'h1C, 5'h02, 5'h04, 5'h07, 5'h09,
                                           5'h0C, 5'h0E, 5'h11, 5'h13, 5'h16, 5'h18, 5'h1B, 5'h1D};

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [3:0] mod12(input logic [4:0] x);
    return (x >= 5'h0C) ? 4'(x - 5'h0C) : x[3:0];
  endfunction : mod12
  function automatic logic [6:0] ac_step(input logic [6:0] a, input logic up);
    return up ? 7'(a + 7'h01) : 7'(a - 7'h01);
  endfunction : ac_step
  function automatic logic [3:0] shift_step(input logic [3:0] s, input logic up);
    return up ? mod12(5'({1'b0, s} + 5'h01)) : ((s == 4'h0) ? 4'hB : 4'(s - 4'h1));
  endfunction : shift_step
  function automatic logic is_dd(input logic [6:0] a);
    return a <= `LCD_DD_LAST;
  endfunction : is_dd
  function automatic logic is_cg(input logic [6:0] a);
    return (a >= `LCD_CG_BASE) && (a <= `LCD_CG_LAST);
  endfunction : is_cg
  function automatic logic is_mk(input logic [6:0] a);
    return (a >= `LCD_MK_BASE) && (a <= `LCD_MK_LAST);
  endfunction : is_mk

  function automatic logic [7:0] mem_rd(input logic [6:0] a);
    if (is_dd(a)) return display_text_memory[a[3:0]];
    if (is_cg(a)) return {3'h0, glyph_memory[a[4:0]]};
    if (is_mk(a)) return {3'h0, icon_memory[3'(a - `LCD_MK_BASE)]};
    return 8'h00;
  endfunction : mem_rd

  // Icon lit on segment j; the table ignores shift_off on purpose
  function automatic logic icon_px(input logic [4:0] j);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < 24; n++) begin
      if (ICON_SEG[n] == j) hit = icon_memory[3'(n / 5)][3'(4 - n % 5)];
    end
    return hit;
  endfunction : icon_px

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  assign setup_ph  = PSEL & ~PENABLE;
  assign access_ph = PSEL & PENABLE;
  assign wr_instr  = access_ph & PWRITE & (PADDR == `LCD_OFS_INSTR);
  assign wr_data   = access_ph & PWRITE & (PADDR == `LCD_OFS_DATA);
  assign rd_data   = access_ph & ~PWRITE & (PADDR == `LCD_OFS_DATA);
  assign addr_ok   = (PADDR == `LCD_OFS_INSTR) | (PADDR == `LCD_OFS_DATA) |
                     ((PADDR == `LCD_OFS_MODE) & ~PWRITE);
  assign PREADY    = access_ph;
  assign PSLVERR   = access_ph & ~addr_ok;
  assign busy_indicator = (state != lcd_core_pkg::ST_IDLE) | ir_go | dr_go;

  // Read data is captured in the setup phase so that it comes from a flop
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup_ph & ~PWRITE) begin
      case (PADDR)
        `LCD_OFS_INSTR: PRDATA <= {24'h00_0000, busy_indicator, address_counter};
        `LCD_OFS_DATA:  PRDATA <= {24'h00_0000, mem_rd(address_counter)};
        `LCD_OFS_MODE:  PRDATA <= {23'h00_0000, shift_off, disp_on, cur_on, blk_on, inc_dir, shift_en};
        default:        PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // Writes while busy are dropped, the host must poll the busy flag first
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      instruction_holding_reg <= 8'h00;
      data_holding_reg        <= 8'h00;
      ir_go                   <= 1'b0;
      dr_go                   <= 1'b0;
    end else begin
      ir_go <= wr_instr & ~busy_indicator;
      dr_go <= wr_data & ~busy_indicator;
      if (wr_instr & ~busy_indicator) instruction_holding_reg <= PWDATA[7:0];
      if (wr_data & ~busy_indicator) data_holding_reg <= PWDATA[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin filter

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      pin_meta  <= 1'b1;
      pin_s2    <= 1'b1;
      pin_s3    <= 1'b1;
      pin_level <= 1'b1;
    end else begin
      pin_meta <= RESET_PIN_N;
      pin_s2   <= pin_meta;
      pin_s3   <= pin_s2;
      if (pin_s2 == pin_s3) pin_level <= pin_s2;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      low_cnt <= 24'h00_0000;
    end else if (pin_level) begin
      low_cnt <= 24'h00_0000;
    end else if (low_cnt < 24'(HOLD_CYC)) begin
      low_cnt <= 24'(low_cnt + 24'h00_0001);
    end
  end

  assign pin_hit = ~pin_level & (low_cnt == 24'(HOLD_CYC - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Instruction execution and busy timing

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state           <= lcd_core_pkg::ST_RUN;
      busy_cnt        <= 24'(POWER_CYC);
      address_counter <= 7'h00;
      inc_dir         <= 1'b1;
      shift_en        <= 1'b0;
      disp_on         <= 1'b0;
      cur_on          <= 1'b0;
      blk_on          <= 1'b0;
      shift_off       <= 4'h0;
    end else if (pin_hit) begin
      state           <= lcd_core_pkg::ST_PIN;
      address_counter <= 7'h00;
      inc_dir         <= 1'b1;
      shift_en        <= 1'b0;
      disp_on         <= 1'b0;
      cur_on          <= 1'b0;
      blk_on          <= 1'b0;
      shift_off       <= 4'h0;
    end else begin
      case (state)
        lcd_core_pkg::ST_PIN: begin
          if (pin_level) begin
            state    <= lcd_core_pkg::ST_RUN;
            busy_cnt <= 24'(POWER_CYC);
          end
        end
        lcd_core_pkg::ST_RUN: begin
          if (busy_cnt <= 24'h00_0001) state <= lcd_core_pkg::ST_IDLE;
          else busy_cnt <= 24'(busy_cnt - 24'h00_0001);
        end
        lcd_core_pkg::ST_IDLE: begin
          if (ir_go) begin
            if (instruction_holding_reg == 8'h01) begin
              address_counter <= 7'h00;
              inc_dir         <= 1'b1;
              shift_off       <= 4'h0;
              state           <= lcd_core_pkg::ST_RUN;
              busy_cnt        <= 24'(CLEAR_CYC);
            end else if (instruction_holding_reg[7:1] == 7'h01) begin
              address_counter <= 7'h00;
              shift_off       <= 4'h0;
              state           <= lcd_core_pkg::ST_RUN;
              busy_cnt        <= 24'(SHORT_CYC);
            end else if (instruction_holding_reg[7:2] == 6'h01) begin
              inc_dir  <= instruction_holding_reg[1];
              shift_en <= instruction_holding_reg[0];
              state    <= lcd_core_pkg::ST_RUN;
              busy_cnt <= 24'(SHORT_CYC);
            end else if (instruction_holding_reg[7:3] == 5'h01) begin
              disp_on  <= instruction_holding_reg[2];
              cur_on   <= instruction_holding_reg[1];
              blk_on   <= instruction_holding_reg[0];
              state    <= lcd_core_pkg::ST_RUN;
              busy_cnt <= 24'(SHORT_CYC);
            end else if (instruction_holding_reg[7]) begin
              address_counter <= instruction_holding_reg[6:0];
              state           <= lcd_core_pkg::ST_RUN;
              busy_cnt        <= 24'(SHORT_CYC);
            end
            // The all-zero test code and other codes fall through as no-ops
          end else if (dr_go | rd_data) begin
            address_counter <= ac_step(address_counter, inc_dir);
            if (shift_en & dr_go) shift_off <= shift_step(shift_off, inc_dir);
            state    <= lcd_core_pkg::ST_RUN;
            busy_cnt <= dr_go ? 24'(SHORT_CYC) : 24'(READ_CYC);
          end
        end
        default: state <= lcd_core_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memories

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < 12; i++) display_text_memory[i] <= `LCD_SPACE;
    end else if (pin_hit | (ir_go & (state == lcd_core_pkg::ST_IDLE) & (instruction_holding_reg == 8'h01))) begin
      for (int i = 0; i < 12; i++) display_text_memory[i] <= `LCD_SPACE;
    end else if (dr_go & (state == lcd_core_pkg::ST_IDLE) & is_dd(address_counter)) begin
      display_text_memory[address_counter[3:0]] <= data_holding_reg;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (dr_go & (state == lcd_core_pkg::ST_IDLE) & is_cg(address_counter)) begin
      glyph_memory[address_counter[4:0]] <= data_holding_reg[4:0];
    end
  end

  // No reset: contents survive both resets, software must initialise them
  always_ff @(posedge CORE_CLK) begin
    if (dr_go & (state == lcd_core_pkg::ST_IDLE) & is_mk(address_counter) & ~pin_hit) begin
      icon_memory[3'(address_counter - `LCD_MK_BASE)] <= data_holding_reg[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display scan, free running on its own counters

  always_comb begin
    seg_j      = 5'(`LCD_LAST_SHIFT - bcnt);
    chr        = 4'((row[3] ? 5'h06 : 5'h00) + seg_j / 5'h05);
    col        = 3'(seg_j % 5'h05);
    txt        = mod12(5'({1'b0, chr} + {1'b0, shift_off}));
    code       = display_text_memory[txt];
    glyph      = (code[7:4] == 4'h0) ? glyph_memory[{code[1:0], row[2:0]}] : 5'h00;
    // Counter position mod 12 even for glyph addresses, where it means nothing
    cursor_pos = mod12(5'({1'b0, mod12({1'b0, address_counter[3:0]})} + 5'h0C - {1'b0, shift_off}));
    if (row == `LCD_ICON_ROW) begin
      px = disp_on & icon_px(seg_j);
    end else begin
      px = disp_on & (glyph[3'(3'h4 - col)] |
                      (cur_on & (row[2:0] == 3'h7) & (chr == cursor_pos)) |
                      (blk_on & blink_phase & (chr == cursor_pos)));
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      bcnt        <= 8'h00;
      row         <= 5'h00;
      frame_cnt   <= 8'h00;
      blink_phase <= 1'b0;
    end else if (bcnt == 8'(ROW_CYC - 1)) begin
      bcnt <= 8'h00;
      row  <= (row == `LCD_ICON_ROW) ? 5'h00 : 5'(row + 5'h01);
      if (row == `LCD_ICON_ROW) begin
        if (frame_cnt == 8'(BLINK_FRAMES - 1)) begin
          frame_cnt   <= 8'h00;
          blink_phase <= ~blink_phase;
        end else begin
          frame_cnt <= 8'(frame_cnt + 8'h01);
        end
      end
    end else begin
      bcnt <= 8'(bcnt + 8'h01);
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      shreg <= 30'h0000_0000;
    end else if (bcnt <= `LCD_LAST_SHIFT) begin
      shreg <= {shreg[28:0], px};
    end
  end

  // Latching only after the last shift keeps half-loaded rows off the glass
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      SEG <= 30'h0000_0000;
      COM <= 17'h0_0001;
    end else if (bcnt == `LCD_LATCH_SLOT) begin
      SEG <= shreg;
      COM <= 17'(17'h0_0001 << row);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  busy_on_data_a: assert property ((state == lcd_core_pkg::ST_IDLE) && dr_go && !ir_go && !pin_hit
    |=> (state == lcd_core_pkg::ST_RUN) && (busy_cnt == 24'(SHORT_CYC)))
    else $error("data write did not start the busy time");
  clear_fill_a: assert property ((state == lcd_core_pkg::ST_IDLE) && ir_go && !pin_hit &&
    (instruction_holding_reg == 8'h01) |=> (display_text_memory[0] == `LCD_SPACE) &&
    (display_text_memory[11] == `LCD_SPACE) && (address_counter == 7'h00) && inc_dir &&
    (busy_cnt == 24'(CLEAR_CYC)))
    else $error("clear did not fill memory or reset the counter");
  home_reset_a: assert property ((state == lcd_core_pkg::ST_IDLE) && ir_go && !pin_hit &&
    (instruction_holding_reg[7:1] == 7'h01) |=> (address_counter == 7'h00) && (shift_off == 4'h0))
    else $error("return home did not reset counter and shift");
  busy_refuse_a: assert property (wr_instr && busy_indicator |=> !ir_go)
    else $error("instruction accepted while busy");
  seg_latch_a: assert property (!$stable(SEG) |-> ($past(bcnt) == `LCD_LATCH_SLOT))
    else $error("segments changed outside the latch slot");
  com_onehot_a: assert property ($onehot(COM))
    else $error("common selection not one-hot");
  icon_hold_a: assert property (!(dr_go && is_mk(address_counter))
    |=> $stable(icon_memory[0]) && $stable(icon_memory[2]) && $stable(icon_memory[4]))
    else $error("icon memory changed without an icon write");
  entry_step_a: assert property ((state == lcd_core_pkg::ST_IDLE) && dr_go && !pin_hit && inc_dir
    |=> address_counter == 7'($past(address_counter) + 7'h01))
    else $error("address counter did not step up");
  pin_busy_a: assert property ((state == lcd_core_pkg::ST_PIN) && pin_level |=> busy_indicator [*8])
    else $error("busy dropped after reset pin release");
  status_read_a: assert property (setup_ph && !PWRITE && (PADDR == `LCD_OFS_INSTR)
    |=> (PRDATA[`LCD_STAT_BUSY] == $past(busy_indicator)) && (PRDATA[6:0] == $past(address_counter)))
    else $error("status read mismatch");

  clear_run_c: cover property ((state == lcd_core_pkg::ST_IDLE) && ir_go && (instruction_holding_reg == 8'h01));
  icon_write_c: cover property (dr_go && is_mk(address_counter));
  pin_reset_c: cover property (pin_hit);
  icon_row_c: cover property ((bcnt == `LCD_LATCH_SLOT) && (row == `LCD_ICON_ROW) && disp_on);

endmodule : lcd_ctl_core

// [lcd_host_model.sv]
// Host processor model: APB master whose cmd task polls busy before each write
`timescale 1ns/100ps
`include "lcd_core_map.svh"

module lcd_host_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released address and data lines must not keep the old value
    paddr <= ~adr;
    pwdata <= ~wd;
  endtask : xfer

  // No limit here: only the bench watchdog ends a wait
  task automatic poll(output logic [31:0] st);
    logic e;
    do begin
      xfer(1'b0, `LCD_OFS_INSTR, 32'h0000_0000, st, e);
    end while (st[`LCD_STAT_BUSY] !== 1'b0);
  endtask : poll

  task automatic cmd(input logic [7:0] adr, input logic [7:0] val);
    logic [31:0] st;
    logic [31:0] r;
    logic        e;
    if (adr == `LCD_OFS_INSTR && val == 8'h00) return;
    poll(st);
    xfer(1'b1, adr, {24'h00_0000, val}, r, e);
  endtask : cmd
endmodule : lcd_host_model

// [tb_lcd_ctl_core.sv]
// Self-checking testbench of the LCD control core
`timescale 1ns/100ps
`include "lcd_core_map.svh"
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (x)); end end

module tb_lcd_ctl_core;
  localparam int unsigned POWER = 200;
  localparam int unsigned HOLD  = 20;
  localparam int unsigned CLEAR = 50;
  logic        clk, rst, reset_pin_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, st, r;
  logic [16:0] com;
  logic [29:0] seg;
  logic        e;
  int          error_cnt = 0;
  int          tests_run = 0;

  lcd_ctl_core #(.POWER_CYC(POWER), .HOLD_CYC(HOLD), .CLEAR_CYC(CLEAR), .SHORT_CYC(10),
    .READ_CYC(12), .ROW_CYC(32), .BLINK_FRAMES(2)) u_lcd_ctl_core (
    .CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RESET_PIN_N(reset_pin_n), .COM(com), .SEG(seg));

  lcd_host_model u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    u_host.xfer(1'b0, a, 32'h0000_0000, d, e);
  endtask : rd

  task automatic rd_data(output logic [31:0] d);
    u_host.poll(st);
    rd(`LCD_OFS_DATA, d);
  endtask : rd_data

  // Two fresh icon rows, so the latched pattern follows the last instruction
  task automatic wait_icons();
    int n;
    u_host.poll(st);
    n = 0;
    repeat (2) begin
      while (com === 17'h1_0000 && n < 3000) begin @(posedge clk); n++; end
      while (com !== 17'h1_0000 && n < 3000) begin @(posedge clk); n++; end
    end
    @(negedge clk);
    `CHK(n < 3000, 1'b1)
    `CHK($onehot(com), 1'b1)
  endtask : wait_icons

  task automatic t_power();
    rd(`LCD_OFS_INSTR, st);
    `CHK(st[7], 1'b1)
    repeat (POWER - 40) @(posedge clk);
    rd(`LCD_OFS_INSTR, st);
    `CHK(st[7], 1'b1)
    u_host.poll(st);
    `CHK(st, 32'h0000_0000)
    $display("test power done");
  endtask : t_power

  task automatic t_entry();
    u_host.cmd(`LCD_OFS_INSTR, 8'h85);
    u_host.cmd(`LCD_OFS_INSTR, 8'h04);
    u_host.cmd(`LCD_OFS_DATA, 8'h41);
    u_host.poll(st);
    `CHK(st, 32'h0000_0004)
    u_host.cmd(`LCD_OFS_INSTR, 8'h06);
    u_host.cmd(`LCD_OFS_DATA, 8'h42);
    u_host.poll(st);
    `CHK(st, 32'h0000_0005)
    u_host.cmd(`LCD_OFS_INSTR, 8'h85);
    rd_data(r);
    `CHK(r[7:0], 8'h41)
    // Shift-on-write stays on so the icon test runs on a shifted display
    u_host.cmd(`LCD_OFS_INSTR, 8'h07);
    u_host.cmd(`LCD_OFS_DATA, 8'h43);
    rd(`LCD_OFS_MODE, r);
    `CHK(r[8:0], 9'h023)
    $display("test entry done");
  endtask : t_entry

  task automatic t_icons();
    logic [7:0]  pat [2][5];
    logic [29:0] exp_seg [3];
    pat = '{'{8'h10, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02}};
    exp_seg = '{30'h0000_0002, 30'h2000_0000, 30'h0000_0000};
    for (int i = 0; i < 3; i++) begin
      u_host.cmd(`LCD_OFS_INSTR, 8'hE0);
      for (int k = 0; k < 5; k++) u_host.cmd(`LCD_OFS_DATA, pat[i % 2][k]);
      u_host.cmd(`LCD_OFS_INSTR, (i < 2) ? 8'h0C : 8'h08);
      wait_icons();
      `CHK(seg, exp_seg[i])
    end
    $display("test icons done");
  endtask : t_icons

  task automatic t_clear();
    u_host.cmd(`LCD_OFS_INSTR, 8'h04);
    u_host.cmd(`LCD_OFS_INSTR, 8'h01);
    rd(`LCD_OFS_INSTR, st);
    `CHK(st[7], 1'b1)
    repeat (CLEAR - 15) @(posedge clk);
    rd(`LCD_OFS_INSTR, st);
    `CHK(st[7], 1'b1)
    u_host.poll(st);
    `CHK(st, 32'h0000_0000)
    rd(`LCD_OFS_MODE, r);
    `CHK(r[1], 1'b1)
    rd_data(r);
    `CHK(r[7:0], 8'h20)
    u_host.cmd(`LCD_OFS_INSTR, 8'hE0);
    rd_data(r);
    `CHK(r[7:0], 8'h10)
    u_host.cmd(`LCD_OFS_INSTR, 8'h83);
    u_host.cmd(`LCD_OFS_INSTR, 8'h02);
    u_host.poll(st);
    `CHK(st, 32'h0000_0000)
    $display("test clear done");
  endtask : t_clear

  task automatic t_bus();
    u_host.xfer(1'b1, 8'h0C, 32'h0000_0000, r, e);
    `CHK(e, 1'b1)
    u_host.xfer(1'b1, `LCD_OFS_MODE, 32'h0000_0000, r, e);
    `CHK(e, 1'b1)
    u_host.xfer(1'b0, `LCD_OFS_INSTR, 32'h0000_0000, r, e);
    `CHK(e, 1'b0)
    $display("test bus done");
  endtask : t_bus

  task automatic t_pin();
    u_host.cmd(`LCD_OFS_INSTR, 8'h87);
    reset_pin_n <= 1'b0;
    repeat (HOLD + 10) @(posedge clk);
    rd(`LCD_OFS_INSTR, st);
    `CHK(st[7], 1'b1)
    reset_pin_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`LCD_OFS_INSTR, st);
    `CHK(st[7], 1'b1)
    u_host.xfer(1'b1, `LCD_OFS_INSTR, 32'h0000_0085, r, e);
    u_host.poll(st);
    `CHK(st, 32'h0000_0000)
    rd(`LCD_OFS_MODE, r);
    `CHK(r, 32'h0000_0002)
    u_host.cmd(`LCD_OFS_INSTR, 8'hE0);
    rd_data(r);
    `CHK(r[7:0], 8'h10)
    $display("test pin reset done");
  endtask : t_pin

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    reset_pin_n = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_power();
    t_entry();
    t_icons();
    t_clear();
    t_bus();
    t_pin();
    final_report();
  end

  // Whole run needs well under this span
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    final_report();
  end
endmodule : tb_lcd_ctl_core
